// file: core/endian_bus_width_aligner.v
// Purpose: align internal accesses to 8/16/32-bit external devices
// Assumes: one request held until accepted; srst is power-on reset
// Notes:   splits wide accesses into consecutive external beats
// Operation
// [RULE1] Endian pin sampled at reset, high little
// [RULE2] Ordinary 8/16/32 wide; DRAM 16/32 only
// [RULE3] PC card interface 8 or 16 only
// [RULE4] Wide access split into consecutive narrow cycles
// [RULE5] Lane alignment and splitting done in hardware
// [RULE6] Line 7 control register matches line 0
// [RULE7] 32-bit big endian byte lanes reversed
// [RULE8] 32-bit big endian words and longword lanes
// [RULE9] 16-bit big endian lanes and longword order
// [RULE10] 8-bit big endian, high byte first
// [RULE11] 32-bit little endian byte lanes direct
// [RULE12] 32-bit little endian words and longword lanes
// [RULE13] 16-bit little endian lanes, low half first
// [RULE14] 8-bit little endian, low byte first
// [RULE15] Unused lane strobes and masks stay negated
`timescale 1ns/1ps
`include "endian_bus_width_aligner_map.vh"

module endian_bus_width_aligner (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        endianSelectPin,
  input  wire        reqValid,
  input  wire        reqWrite,
  input  wire [1:0]  reqSize,
  input  wire [1:0]  reqAddr,
  input  wire [31:0] reqWdata,
  input  wire [1:0]  devWidth,
  input  wire [1:0]  devKind,
  input  wire        extReady,
  input  wire [31:0] extRdata,
  input  wire        csWriteStrobe0,
  input  wire        csWriteStrobe7,
  input  wire [15:0] csWriteData,
  output reg         reqReady,
  output reg         respValid,
  output reg  [31:0] respRdata,
  output reg         respError,
  output reg         extCycle,
  output reg         extWrite,
  output reg  [1:0]  extAddr,
  output reg  [31:0] extWdata,
  output reg         lane0_write_strobe,
  output reg         lane1_write_strobe,
  output reg         lane2_write_strobe,
  output reg         lane3_write_strobe,
  output reg         sdram_lane0_mask,
  output reg         sdram_lane1_mask,
  output reg         sdram_lane2_mask,
  output reg         sdram_lane3_mask,
  output reg         littleEndian,
  output reg  [15:0] chip_select_0_control,
  output reg  [15:0] chip_select_7_control
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Bytes per beat for a device width
  function [1:0] beatBytesOf;
    input [1:0] w;
    begin
      case (w)
        `WIDTH_8:  beatBytesOf = 2'h1;
        `WIDTH_16: beatBytesOf = 2'h2;
        default:   beatBytesOf = 2'h0;
      endcase
    end
  endfunction

  // Bytes in an access (0 means four)
  function [1:0] accBytesOf;
    input [1:0] s;
    begin
      case (s)
        `SIZE_BYTE: accBytesOf = 2'h1;
        `SIZE_WORD: accBytesOf = 2'h2;
        default:    accBytesOf = 2'h0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg         state_reg;
  reg         state_next;
  reg         endianCaught_reg;
  reg  [1:0]  beatsLeft_reg;
  reg  [1:0]  beatIndex_reg;
  reg  [1:0]  size_reg;
  reg  [1:0]  baseAddr_reg;
  reg  [1:0]  width_reg;
  reg         write_reg;
  reg  [31:0] wdata_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdataNext;
  reg  [1:0]  beatsNeeded;
  reg         widthLegal;
  reg  [1:0]  beatBytes;
  reg  [1:0]  beatAddr;
  reg  [31:0] beatData;
  reg  [4:0]  beatShift;
  reg         shown_reg;
  wire        beatDone;
  wire        beatOn;
  wire [31:0] laneData;
  wire [3:0]  laneEnable;
  wire [15:0] cs0Read;
  wire [15:0] cs7Read;

  // ----------------------------------------
  // Byte order capture
  // ----------------------------------------
  // [RULE1] catch pin at reset
  // Clocked capture while reset is held; the pin is a strap
  always @(posedge core_clk) begin
    if (srst) begin
      endianCaught_reg <= endianSelectPin;
    end
  end

  // ----------------------------------------
  // Request checks
  // ----------------------------------------
  // [RULE2] [RULE3] legal width per kind
  always @* begin
    case (devKind)
      `KIND_SDRAM:  widthLegal = (devWidth == `WIDTH_16) || (devWidth == `WIDTH_32);
      `KIND_PCCARD: widthLegal = (devWidth == `WIDTH_8) || (devWidth == `WIDTH_16);
      default:      widthLegal = (devWidth != 2'h3);
    endcase
    // [RULE4] beat count from sizes
    case ({reqSize, devWidth})
      {`SIZE_WORD, `WIDTH_8}:  beatsNeeded = 2'h1;
      {`SIZE_LONG, `WIDTH_8}:  beatsNeeded = 2'h3;
      {`SIZE_LONG, `WIDTH_16}: beatsNeeded = 2'h1;
      default:                 beatsNeeded = 2'h0;
    endcase
  end

  // ----------------------------------------
  // Beat formation
  // ----------------------------------------
  // [RULE9] [RULE10] [RULE13] [RULE14] beat order
  // Big endian sends the most significant part first, little the least
  always @* begin
    beatBytes = (beatBytesOf(width_reg) == 2'h0) ? accBytesOf(size_reg) :
                (accBytesOf(size_reg) == 2'h1) ? 2'h1 : beatBytesOf(width_reg);
    beatAddr  = baseAddr_reg + (beatIndex_reg << (beatBytes == 2'h2 ? 1'h1 : 1'h0));
    if (littleEndian)
      beatShift = {beatIndex_reg, 3'h0} << (beatBytes == 2'h2 ? 1'h1 : 1'h0);
    else
      beatShift = {beatsLeft_reg, 3'h0} << (beatBytes == 2'h2 ? 1'h1 : 1'h0);
    beatData  = wdata_reg >> beatShift;
  end

  // [RULE5] [RULE7] [RULE8] [RULE11] [RULE12] lane steering
  lane_steer u_steer (
    .beatData     (beatData),
    .beatBytes    (beatBytes),
    .beatAddr     (beatAddr),
    .devWidth     (width_reg),
    .littleEndian (littleEndian),
    .laneData     (laneData),
    .laneEnable   (laneEnable)
  );

  // Gather read data back into access order
  always @* begin
    rdataNext = rdata_reg;
    case (width_reg)
      `WIDTH_8:
        rdataNext = rdata_reg | ({24'h000000, extRdata[7:0]} << beatShift);
      `WIDTH_16:
        if (beatBytes == 2'h1)
          rdataNext = {24'h000000, laneEnable[1] ? extRdata[15:8] : extRdata[7:0]};
        else
          rdataNext = rdata_reg | ({16'h0000, extRdata[15:0]} << beatShift);
      default:
        rdataNext = (extRdata & {{8{laneEnable[3]}}, {8{laneEnable[2]}},
                                 {8{laneEnable[1]}}, {8{laneEnable[0]}}})
                    >> ({littleEndian ? beatAddr : 2'h0, 3'h0} +
                        (!littleEndian && beatBytes == 2'h1 ? {~beatAddr, 3'h0} :
                         (!littleEndian && beatBytes == 2'h2 && !beatAddr[1]) ? 5'h10 :
                         5'h00));
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // A beat completes only on a ready that answers the beat on the pins
  assign beatDone = shown_reg && extReady;
  assign beatOn   = (state_reg == `ST_CYCLE) && !beatDone;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ST_IDLE:  if (reqValid && reqReady && widthLegal) state_next = `ST_CYCLE;
      `ST_CYCLE: if (beatDone && beatsLeft_reg == 2'h0) state_next = `ST_IDLE;
      default:   state_next = `ST_IDLE;
    endcase
  end

  // Beat counting, data capture and response outputs, all registered
  always @(posedge core_clk) begin
    if (srst) begin
      state_reg     <= `ST_IDLE;
      shown_reg     <= 1'b0;
      littleEndian  <= 1'b0;
      beatsLeft_reg <= 2'h0;
      beatIndex_reg <= 2'h0;
      size_reg      <= `SIZE_BYTE;
      baseAddr_reg  <= 2'h0;
      width_reg     <= `WIDTH_32;
      write_reg     <= 1'b0;
      wdata_reg     <= 32'h00000000;
      rdata_reg     <= 32'h00000000;
      reqReady      <= 1'b0;
      respValid     <= 1'b0;
      respRdata     <= 32'h00000000;
      respError     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      littleEndian <= endianCaught_reg;
      respValid    <= 1'b0;
      respError    <= 1'b0;
      case (state_reg)
        `ST_IDLE: begin
          reqReady  <= 1'b1;
          shown_reg <= 1'b0;
          if (reqValid && reqReady) begin
            reqReady      <= 1'b0;
            size_reg      <= reqSize;
            baseAddr_reg  <= reqAddr;
            width_reg     <= devWidth;
            write_reg     <= reqWrite;
            wdata_reg     <= reqWdata;
            rdata_reg     <= 32'h00000000;
            beatsLeft_reg <= beatsNeeded;
            beatIndex_reg <= 2'h0;
            // Unsupported width is answered at once, no bus cycle
            if (!widthLegal) begin
              respValid <= 1'b1;
              respError <= 1'b1;
            end
          end
        end
        default: begin
          // Pins reload after every completed beat, so a ready never meets stale lanes
          shown_reg <= !beatDone;
          if (beatDone) begin
            rdata_reg     <= rdataNext;
            beatsLeft_reg <= beatsLeft_reg - 2'h1;
            beatIndex_reg <= beatIndex_reg + 2'h1;
            if (beatsLeft_reg == 2'h0) begin
              respValid <= 1'b1;
              respRdata <= rdataNext;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // External pins
  // ----------------------------------------
  // [RULE15] strobes only on carrying lanes
  always @(posedge core_clk) begin
    if (srst) begin
      extCycle           <= 1'b0;
      extWrite           <= 1'b0;
      extAddr            <= 2'h0;
      extWdata           <= 32'h00000000;
      lane0_write_strobe <= 1'b0;
      lane1_write_strobe <= 1'b0;
      lane2_write_strobe <= 1'b0;
      lane3_write_strobe <= 1'b0;
      sdram_lane0_mask   <= 1'b0;
      sdram_lane1_mask   <= 1'b0;
      sdram_lane2_mask   <= 1'b0;
      sdram_lane3_mask   <= 1'b0;
    end else begin
      // Pins load from the held beat; cycle and strobes drop for one cycle after each ready but the last
      extCycle           <= beatOn;
      extWrite           <= write_reg;
      extAddr            <= beatAddr;
      extWdata           <= write_reg ? laneData : 32'h00000000;
      lane0_write_strobe <= beatOn && write_reg && laneEnable[0];
      lane1_write_strobe <= beatOn && write_reg && laneEnable[1];
      lane2_write_strobe <= beatOn && write_reg && laneEnable[2];
      lane3_write_strobe <= beatOn && write_reg && laneEnable[3];
      sdram_lane0_mask   <= beatOn && laneEnable[0];
      sdram_lane1_mask   <= beatOn && laneEnable[1];
      sdram_lane2_mask   <= beatOn && laneEnable[2];
      sdram_lane3_mask   <= beatOn && laneEnable[3];
    end
  end

  // ----------------------------------------
  // Chip-select control registers
  // ----------------------------------------
  // [RULE6] identical line 7 register
  chip_select_control u_cs0 (
    .core_clk    (core_clk),
    .srst        (srst),
    .writeStrobe (csWriteStrobe0),
    .writeData   (csWriteData),
    .readData    (cs0Read)
  );

  chip_select_control u_cs7 (
    .core_clk    (core_clk),
    .srst        (srst),
    .writeStrobe (csWriteStrobe7),
    .writeData   (csWriteData),
    .readData    (cs7Read)
  );

  // Registered copies so top outputs come from flops
  always @(posedge core_clk) begin
    if (srst) begin
      chip_select_0_control <= 16'h0000;
      chip_select_7_control <= 16'h0000;
    end else begin
      chip_select_0_control <= cs0Read;
      chip_select_7_control <= cs7Read;
    end
  end

endmodule

// file: core/endian_bus_width_aligner_map.vh
// Purpose: constants for the endian and bus width aligner
// Assumes: included by bare name from core design files
// Notes:   definitions only
`ifndef ENDIAN_BUS_WIDTH_ALIGNER_MAP_VH
`define ENDIAN_BUS_WIDTH_ALIGNER_MAP_VH

// ----------------------------------------
// Access sizes (internal request)
// ----------------------------------------
`define SIZE_BYTE  2'h0
`define SIZE_WORD  2'h1
`define SIZE_LONG  2'h2

// ----------------------------------------
// External device widths
// ----------------------------------------
`define WIDTH_8    2'h0
`define WIDTH_16   2'h1
`define WIDTH_32   2'h2

// ----------------------------------------
// Device kinds
// ----------------------------------------
`define KIND_ORDINARY 2'h0
`define KIND_SDRAM    2'h1
`define KIND_PCCARD   2'h2

// ----------------------------------------
// Sequencer states, control register reset value and width
// ----------------------------------------
`define ST_IDLE    1'h0
`define ST_CYCLE   1'h1
`define CSCTRL_RESET 7'h00
`define CSCTRL_WIDTH 7

`endif

// file: core/lane_steer.v
// Purpose: place one external beat onto the four byte lanes
// Assumes: beat width and byte order fixed for the beat
// Notes:   pure combinational, used by the sequencer each beat
`timescale 1ns/1ps
`include "endian_bus_width_aligner_map.vh"

module lane_steer (
  input  wire [31:0] beatData,
  input  wire [1:0]  beatBytes,
  input  wire [1:0]  beatAddr,
  input  wire [1:0]  devWidth,
  input  wire        littleEndian,
  output reg  [31:0] laneData,
  output reg  [3:0]  laneEnable
);

  // ----------------------------------------
  // Lane placement
  // ----------------------------------------
  // Lane number for a byte offset on a 32-bit bus
  function [1:0] laneOf;
    input [1:0] off;
    input       le;
    begin
      laneOf = le ? off : ~off;
    end
  endfunction

  reg [1:0] lane;

  // Beat data arrives right aligned; shift it onto its lanes
  always @* begin
    laneData   = 32'h00000000;
    laneEnable = 4'h0;
    lane       = 2'h0;
    case (devWidth)
      `WIDTH_8: begin
        laneData   = {24'h000000, beatData[7:0]};
        laneEnable = 4'h1;
      end
      `WIDTH_16: begin
        if (beatBytes == 2'h1) begin
          // Even offset takes the high lane in big endian only
          lane       = {1'b0, beatAddr[0] ^ ~littleEndian};
          laneData   = lane[0] ? {16'h0000, beatData[7:0], 8'h00}
                               : {24'h000000, beatData[7:0]};
          laneEnable = lane[0] ? 4'h2 : 4'h1;
        end else begin
          laneData   = {16'h0000, beatData[15:0]};
          laneEnable = 4'h3;
        end
      end
      default: begin
        if (beatBytes == 2'h1) begin
          lane       = laneOf(beatAddr, littleEndian);
          laneData   = {24'h000000, beatData[7:0]} << {lane, 3'h0};
          laneEnable = 4'h1 << lane;
        end else if (beatBytes == 2'h2) begin
          // Upper half for big endian offset 0 or little endian offset 2
          if (beatAddr[1] ^ ~littleEndian) begin
            laneData   = {beatData[15:0], 16'h0000};
            laneEnable = 4'hC;
          end else begin
            laneData   = {16'h0000, beatData[15:0]};
            laneEnable = 4'h3;
          end
        end else begin
          laneData   = beatData;
          laneEnable = 4'hF;
        end
      end
    endcase
  end

endmodule

// file: core/chip_select_control.v
// Purpose: output-condition control register for one chip-select line
// Assumes: loaded by the surrounding controller through a write pulse
// Notes:   same layout for every line; upper bits read as zero
`timescale 1ns/1ps
`include "endian_bus_width_aligner_map.vh"

module chip_select_control (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        writeStrobe,
  input  wire [15:0] writeData,
  output wire [15:0] readData
);

  reg [`CSCTRL_WIDTH-1:0] control_reg;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Only bits 6..0 hold state
  always @(posedge core_clk) begin
    if (srst) begin
      control_reg <= `CSCTRL_RESET;
    end else if (writeStrobe) begin
      control_reg <= writeData[`CSCTRL_WIDTH-1:0];
    end
  end

  assign readData = {9'h000, control_reg};

endmodule

// file: verif/endian_bus_width_aligner_chk.sv
// Purpose: port-level checks for endian_bus_width_aligner
// Assumes: one clock domain, srst synchronous active high
// Notes:   bound to the design from the bench top file
`timescale 1ns/1ps
`include "endian_bus_width_aligner_map.vh"

module endian_bus_width_aligner_chk (
  input wire        core_clk,
  input wire        srst,
  input wire        reqValid,
  input wire        reqReady,
  input wire [1:0]  devWidth,
  input wire [1:0]  devKind,
  input wire        extReady,
  input wire        extCycle,
  input wire        extWrite,
  input wire        respValid,
  input wire        respError,
  input wire        lane0_write_strobe,
  input wire        lane1_write_strobe,
  input wire        lane2_write_strobe,
  input wire        lane3_write_strobe,
  input wire        littleEndian,
  input wire        csWriteStrobe7,
  input wire [15:0] csWriteData,
  input wire [15:0] chip_select_0_control,
  input wire [15:0] chip_select_7_control
);
  wire [3:0] strobes;

  // Strobes gathered so lane rules read as one vector
  assign strobes = {lane3_write_strobe, lane2_write_strobe, lane1_write_strobe,
                    lane0_write_strobe};

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  read_no_strobe_a: assert property (extCycle && !extWrite |-> strobes == 4'h0)
    else $error("write strobe on a read beat");
  narrow_lane_a: assert property (extCycle && devWidth == `WIDTH_8 |->
    strobes[3:1] == 3'h0) else $error("upper lane strobe on 8-bit device");
  half_lane_a: assert property (extCycle && devWidth == `WIDTH_16 |->
    strobes[3:2] == 2'h0) else $error("upper lane strobe on 16-bit device");
  endian_hold_a: assert property (!$past(srst) && !$past(srst, 2) |->
    $stable(littleEndian)) else $error("byte order changed outside reset");
  resp_pulse_a: assert property (respValid |=> !respValid)
    else $error("response longer than one cycle");
  busy_refuse_a: assert property (extCycle |-> !reqReady)
    else $error("ready while a beat is on the bus");
  // Pins load one cycle after the take; a refused access answers at once
  take_start_a: assert property (reqValid && reqReady |->
    (##1 respError) or (##2 extCycle)) else $error("taken access did not start");
  last_beat_a: assert property (respValid && !respError |->
    $past(extCycle && extReady)) else $error("response without a final beat");
  sdram_narrow_a: assert property (reqValid && reqReady && devKind == `KIND_SDRAM &&
    devWidth == `WIDTH_8 |=> respValid && respError) else $error("8-bit dram not refused");
  card_wide_a: assert property (reqValid && reqReady && devKind == `KIND_PCCARD &&
    devWidth == `WIDTH_32 |=> respValid && respError) else $error("32-bit card not refused");
  // Register loads on the strobe edge, the output copy one edge later
  line7_load_a: assert property (csWriteStrobe7 |-> ##2
    chip_select_7_control == {9'h000, $past(csWriteData[6:0], 2)}) else $error("line 7 load");
  control_zero_a: assert property ($fell(srst) |-> chip_select_0_control == 16'h0000 &&
    chip_select_7_control == 16'h0000) else $error("control register not cleared");
endmodule

// file: verif/ext_device_model.sv
// Purpose: external memory answering beats on the byte lanes
// Assumes: pins stand from beat start until ready is seen
// Notes:   variable wait per beat; released read lanes toggle
`timescale 1ns/1ps

module ext_device_model (
  input  wire        core_clk,
  input  wire        srst,
  input  wire [1:0]  delay,
  input  wire        extCycle,
  input  wire        extWrite,
  input  wire [1:0]  extAddr,
  input  wire [31:0] extWdata,
  input  wire [3:0]  strobes,
  output reg         extReady,
  output reg  [31:0] extRdata
);
  reg [7:0] mem_reg [0:15];
  reg [1:0] waitCnt_reg;
  integer   k;

  // Ready is a single pulse and never repeats next cycle, so a lingering beat is not taken twice
  always @(posedge core_clk) begin
    extReady <= 1'b0;
    extRdata <= ~extRdata;
    if (srst) begin
      waitCnt_reg <= 2'h0;
      extRdata <= 32'h5A5A5A5A;
    end else if (extCycle && !extReady) begin
      if (waitCnt_reg < delay) begin
        waitCnt_reg <= waitCnt_reg + 2'h1;
      end else begin
        waitCnt_reg <= 2'h0;
        extReady <= 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
          extRdata[8*k +: 8] <= mem_reg[{extAddr, k[1:0]}];
          if (extWrite && strobes[k]) begin
            mem_reg[{extAddr, k[1:0]}] <= extWdata[8*k +: 8];
          end
        end
      end
    end
  end
endmodule

// file: verif/endian_bus_width_aligner_bench.sv
// Purpose: self-checking bench for endian_bus_width_aligner
// Assumes: design inputs change on the falling edge
// Notes:   write then read back every size, aligned offset and width
`timescale 1ns/1ps
`include "endian_bus_width_aligner_map.vh"

module endian_bus_width_aligner_bench;
  reg         core_clk, srst, endianSelectPin, reqValid, reqWrite;
  reg  [1:0]  reqSize, reqAddr, devWidth, devKind, delay;
  reg  [31:0] reqWdata, lfsr;
  reg         csWriteStrobe0, csWriteStrobe7;
  reg  [15:0] csWriteData;
  wire        extReady, reqReady, respValid, respError, extCycle, extWrite, littleEndian;
  wire [31:0] extRdata, respRdata, extWdata;
  wire [1:0]  extAddr;
  wire [3:0]  strobes, masks;
  wire [15:0] cs0, cs7;
  integer     errors, cmp_count, le, w, sz, a;

  endian_bus_width_aligner i_dut (.core_clk(core_clk), .srst(srst),
    .endianSelectPin(endianSelectPin), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqSize(reqSize), .reqAddr(reqAddr), .reqWdata(reqWdata), .devWidth(devWidth),
    .devKind(devKind), .extReady(extReady), .extRdata(extRdata),
    .csWriteStrobe0(csWriteStrobe0), .csWriteStrobe7(csWriteStrobe7),
    .csWriteData(csWriteData), .reqReady(reqReady), .respValid(respValid),
    .respRdata(respRdata), .respError(respError), .extCycle(extCycle), .extWrite(extWrite),
    .extAddr(extAddr), .extWdata(extWdata), .lane0_write_strobe(strobes[0]),
    .lane1_write_strobe(strobes[1]), .lane2_write_strobe(strobes[2]),
    .lane3_write_strobe(strobes[3]), .sdram_lane0_mask(masks[0]), .sdram_lane1_mask(masks[1]),
    .sdram_lane2_mask(masks[2]), .sdram_lane3_mask(masks[3]), .littleEndian(littleEndian),
    .chip_select_0_control(cs0), .chip_select_7_control(cs7));

  ext_device_model i_mem (.core_clk(core_clk), .srst(srst), .delay(delay),
    .extCycle(extCycle), .extWrite(extWrite), .extAddr(extAddr), .extWdata(extWdata),
    .strobes(strobes), .extReady(extReady), .extRdata(extRdata));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask

  // One access; each beat is compared with lanes worked out from offset, width and order
  task access(input wr, input [1:0] sz, input [1:0] a, input [1:0] w, input [1:0] kd,
    input [31:0] v, input bad);
    integer nb, wb, s, b, x, ln, j, t;
    reg [3:0]  lanes;
    reg [31:0] dat, m;
    begin
      nb = 1 << sz;
      wb = 1 << w;
      m = (nb == 4) ? 32'hFFFFFFFF : (32'h00000001 << (8 * nb)) - 32'h00000001;
      b = 0;
      t = 0;
      do begin
        @(negedge core_clk);
        t = t + 1;
      end while (reqReady !== 1'b1 && t < 20);
      if (reqReady !== 1'b1) errors = errors + 1;
      reqValid = 1'b1;
      reqWrite = wr;
      reqSize = sz;
      reqAddr = a;
      reqWdata = v & m;
      devWidth = w;
      devKind = kd;
      delay = lfsr[1:0];
      @(negedge core_clk);
      reqValid = 1'b0;
      for (t = 0; t < 60 && respValid !== 1'b1; t = t + 1) begin
        if (extCycle === 1'b1 && extReady === 1'b1) begin
          s = (nb > wb) ? a + b * wb : a;
          lanes = 4'h0;
          dat = 32'h00000000;
          for (x = s; x < s + ((nb > wb) ? wb : nb); x = x + 1) begin
            j = le ? x - a : nb - 1 - (x - a);
            ln = le ? x % wb : wb - 1 - x % wb;
            lanes[ln] = 1'b1;
            dat[8*ln +: 8] = v[8*j +: 8];
          end
          check({30'h0, extAddr}, s);
          check({28'h0, strobes}, wr ? lanes : 4'h0);
          if (wr) check(extWdata & {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}},
            dat);
          if (kd == `KIND_SDRAM) check({28'h0, masks}, lanes);
          b = b + 1;
        end
        @(negedge core_clk);
      end
      // A hung access adds one error here; the run goes on to the closing report
      if (respValid !== 1'b1) errors = errors + 1;
      check({31'h0, respError}, bad);
      check(b, bad ? 0 : ((nb > wb) ? nb / wb : 1));
      if (!wr && !bad) check(respRdata & m, v & m);
    end
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Two resets, one per byte order, the second in mid-run
  initial begin
    {srst, endianSelectPin, reqValid, reqWrite, csWriteStrobe0, csWriteStrobe7} = 6'h20;
    {reqSize, reqAddr, devWidth, devKind, delay} = 10'h000;
    reqWdata = 32'h00000000;
    csWriteData = 16'h0000;
    errors = 0;
    cmp_count = 0;
    lfsr = 32'h00005349;
    for (le = 0; le < 2; le = le + 1) begin
      @(negedge core_clk);
      endianSelectPin = le[0];
      srst = 1'b1;
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      repeat (2) @(negedge core_clk);
      check({31'h0, littleEndian}, le);
      check({cs0, cs7}, 32'h00000000);
      csWriteData = lfsr[15:0];
      csWriteStrobe0 = 1'b1;
      csWriteStrobe7 = 1'b1;
      @(negedge core_clk);
      {csWriteStrobe0, csWriteStrobe7} = 2'h0;
      @(negedge core_clk);
      check({cs0, cs7}, {2{9'h000, lfsr[6:0]}});
      for (w = 0; w < 3; w = w + 1) begin
        for (sz = 0; sz < 3; sz = sz + 1) begin
          for (a = 0; a < 4; a = a + (1 << sz)) begin
            lfsr = lfsr_next(lfsr);
            devKind = (w == 2) ? {1'b0, lfsr[2]} : (w == 1) ? lfsr[3:2] % 3 : {lfsr[2], 1'b0};
            access(1'b1, sz[1:0], a[1:0], w[1:0], devKind, lfsr, 1'b0);
            access(1'b0, sz[1:0], a[1:0], w[1:0], devKind, lfsr, 1'b0);
          end
        end
      end
    end
    access(1'b1, `SIZE_LONG, 2'h0, `WIDTH_8, `KIND_SDRAM, lfsr, 1'b1);
    access(1'b0, `SIZE_WORD, 2'h0, `WIDTH_32, `KIND_PCCARD, lfsr, 1'b1);
    print_verdict;
  end
endmodule

bind endian_bus_width_aligner endian_bus_width_aligner_chk i_chk (.core_clk(core_clk),
  .srst(srst), .reqValid(reqValid), .reqReady(reqReady), .devWidth(devWidth),
  .devKind(devKind), .extReady(extReady), .extCycle(extCycle), .extWrite(extWrite),
  .respValid(respValid), .respError(respError), .lane0_write_strobe(lane0_write_strobe),
  .lane1_write_strobe(lane1_write_strobe), .lane2_write_strobe(lane2_write_strobe),
  .lane3_write_strobe(lane3_write_strobe), .littleEndian(littleEndian),
  .csWriteStrobe7(csWriteStrobe7), .csWriteData(csWriteData),
  .chip_select_0_control(chip_select_0_control),
  .chip_select_7_control(chip_select_7_control));
